// *** bwsup_host.v ***
// host-side boot sequencer that drives the board management watchdog
// assumes a device command port with a one-cycle strobe and a done pulse,
// and software on avalon-mm issuing boot steps in order
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "bwsup_consts.vh"

// Notes on behaviour
// - host loads reset guard once the bootstrap cpu runs firmware
// - host arms self-test guard right before dropping reset guard
// - host disables self-test guard near end of self-test
// - over 1 GB with full memory test: host extends timeout first
// - host disables watchdog before boot password prompt
// - removable or unknown media: disable watchdog before os loader
// - hard drive boot: disable or arm 5, 10, 15 or 20 minutes
// - network boot uses the same load-guard option as hard drive boot, same four choices
// - entering setup disables the watchdog regardless of options
// - os driver disables watchdog after a good load
module bwsup_host #(
  parameter DATA_W = 32,
  parameter STEP_W = 3
) (
  input wire i_clk_sys,
  input wire i_resetn,
  // avalon-mm slave
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // device watchdog command port
  output reg o_wd_cmd_valid,
  output reg [2:0] o_wd_cmd,
  output reg [DATA_W-1:0] o_wd_cmd_data,
  input wire i_wd_done,
  input wire [DATA_W-1:0] i_wd_rdata,
  output reg o_selftest_log
);

  localparam ST_IDLE = 4'h1;
  localparam ST_CMD = 4'h2;
  localparam ST_WAIT = 4'h4;
  localparam ST_NEXT = 4'h8;

  // register map as seen by software:
  //   ctrl    bit 0 go, bits 3:1 boot step; reads back step and busy
  //   status  bit 0 full memory test, bits 15:1 fitted memory in mb
  //   timeout raw guard time, media code and load-guard option
  //   expiry  last expiry status fetched from the device
  // a step runs to completion before another go is taken, so a
  // half-issued arm and disable pair never leaves the device unguarded

  reg [3:0] state;
  reg [STEP_W-1:0] step;
  reg [1:0] sub;
  reg busy;
  reg [31:0] timeout;
  reg [31:0] expiry;
  reg [15:0] mem_mb;
  reg full_test;
  reg [2:0] last_cmd;
  reg [3:0] next_state;
  reg [STEP_W-1:0] next_step;
  reg [1:0] next_sub;
  reg next_busy;

  ////////////////////////////////////////////////////////////////////////
  // option code to minutes: 1..4 map to 5..20, 0 means disabled
  function [7:0] lg_minutes;
    input [2:0] opt;
    begin
      lg_minutes = {5'h00, opt} * `BWSUP_LG_STEP_MIN;
    end
  endfunction

  // address compare shared by the read mux, the write path and go
  function addr_hit;
    input [3:0] addr;
    input [3:0] base;
    begin
      addr_hit = (addr == base);
    end
  endfunction

  // option codes above the last minute step are treated as off, so a
  // stray value can never arm a guard of unknown length
  function opt_off;
    input [2:0] opt;
    begin
      opt_off = (opt == `BWSUP_OPT_OFF) || (opt > `BWSUP_OPT_MAX);
    end
  endfunction

  // per-step plan: command for sub-step 0 and 1, or 3'h0 to finish
  function [2:0] plan_cmd;
    input [2:0] stp;
    input [1:0] sb;
    input [1:0] media;
    input [2:0] opt;
    input big;
    begin
      plan_cmd = `BWSUP_CMD_NONE;
      case (stp)
        `BWSUP_S_RGUARD_LOAD: begin
          if (sb == 2'h0)
            plan_cmd = `BWSUP_CMD_LOAD_RGUARD;
        end
        `BWSUP_S_POST_ENTER: begin
          // arm first so no unguarded gap; arming replaces the role
          if (sb == 2'h0)
            plan_cmd = `BWSUP_CMD_ARM_STEST;
          else if (sb == 2'h1)
            plan_cmd = `BWSUP_CMD_READ_STATUS;
        end
        `BWSUP_S_MEM_EXTEND: begin
          if (sb == 2'h0 && big)
            plan_cmd = `BWSUP_CMD_EXTEND;
        end
        `BWSUP_S_POST_DONE: begin
          if (sb == 2'h0)
            plan_cmd = `BWSUP_CMD_DISABLE;
        end
        `BWSUP_S_BOOT_PWD: begin
          if (sb == 2'h0)
            plan_cmd = `BWSUP_CMD_DISABLE;
        end
        `BWSUP_S_OS_LOAD: begin
          if (sb == 2'h0) begin
            if (media == `BWSUP_M_REMOV || media == `BWSUP_M_UNKNOWN)
              plan_cmd = `BWSUP_CMD_DISABLE;
            else if (opt_off(opt))
              plan_cmd = `BWSUP_CMD_DISABLE;
            else
              plan_cmd = `BWSUP_CMD_ARM_LOAD;
          end
        end
        `BWSUP_S_SETUP: begin
          if (sb == 2'h0)
            plan_cmd = `BWSUP_CMD_DISABLE;
        end
        default: begin
          if (sb == 2'h0)
            plan_cmd = `BWSUP_CMD_DISABLE;
        end
      endcase
    end
  endfunction

  // plan inputs taken apart from the software registers
  wire [1:0] media = timeout[`BWSUP_T_MEDIA_HI:`BWSUP_T_MEDIA_LO];
  wire [2:0] lg_opt = timeout[`BWSUP_T_OPT_HI:`BWSUP_T_OPT_LO];
  // only a full test over the threshold can outrun the guard
  wire big_mem = full_test && (mem_mb > `BWSUP_BIG_MEM_MB);
  wire [2:0] cur_cmd = plan_cmd(step, sub, media, lg_opt, big_mem);

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then answer
  wire access = (i_avs_read || i_avs_write) && o_avs_waitrequest;
  wire go = i_avs_write && o_avs_waitrequest &&
    addr_hit(i_avs_address, `BWSUP_A_CTRL) &&
    i_avs_writedata[`BWSUP_C_GO] && !busy;

  // waitrequest drops for exactly one cycle per access, so a master that
  // holds its request is accepted again two cycles later
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !access;
    end
  end

  // read mux; unmapped addresses read as zero
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_avs_readdata <= `BWSUP_ZERO32;
    end else if (access && i_avs_read) begin
      if (addr_hit(i_avs_address, `BWSUP_A_CTRL))
        o_avs_readdata <= {28'h0000000, step, busy};
      else if (addr_hit(i_avs_address, `BWSUP_A_STATUS))
        o_avs_readdata <= {16'h0000, mem_mb[14:0], full_test};
      else if (addr_hit(i_avs_address, `BWSUP_A_TIMEOUT))
        o_avs_readdata <= timeout;
      else if (addr_hit(i_avs_address, `BWSUP_A_EXPIRY))
        o_avs_readdata <= expiry;
      else
        o_avs_readdata <= `BWSUP_ZERO32;
    end
  end

  // configuration writes; ctrl writes only start steps, and a ctrl write
  // while busy is dropped so a step cannot be torn halfway
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      timeout <= `BWSUP_ZERO32;
      mem_mb <= 16'h0000;
      full_test <= 1'b0;
    end else if (access && !i_avs_read && i_avs_write) begin
      if (addr_hit(i_avs_address, `BWSUP_A_STATUS)) begin
        full_test <= i_avs_writedata[0];
        mem_mb <= {1'b0, i_avs_writedata[15:1]};
      end else if (addr_hit(i_avs_address, `BWSUP_A_TIMEOUT)) begin
        timeout <= i_avs_writedata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // step sequencer
  // command port timing, counted from the accepted go write:
  //   +1 state moves to cmd, +2 strobe stands for one cycle, operand until the next command
  //   the device may take any time; done moves to next, then cmd again
  //   there is no local timer: a device that never answers leaves busy
  //   set, which software sees in ctrl and must handle itself

  // next-state part: which step, sub-step and state follow
  always @* begin
    next_state = state;
    next_step = step;
    next_sub = sub;
    next_busy = busy;
    case (state)
      ST_IDLE: begin
        if (go) begin
          next_step = i_avs_writedata[`BWSUP_C_STEP_HI:`BWSUP_C_STEP_LO];
          next_sub = 2'h0;
          next_busy = 1'b1;
          next_state = ST_CMD;
        end
      end
      ST_CMD: begin
        // an empty plan slot ends the step and frees ctrl
        if (cur_cmd == `BWSUP_CMD_NONE) begin
          next_busy = 1'b0;
          next_state = ST_IDLE;
        end else begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // the device owns the timing of its answer
        if (i_wd_done)
          next_state = ST_NEXT;
      end
      ST_NEXT: begin
        next_sub = sub + 2'h1;
        next_state = ST_CMD;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer state registers
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      step <= {STEP_W{1'b0}};
      sub <= 2'h0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      step <= next_step;
      sub <= next_sub;
      busy <= next_busy;
    end
  end

  // command strobe and operand; the strobe stands one cycle and the
  // operand until the next command, so the device may latch it late
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      last_cmd <= `BWSUP_CMD_NONE;
      o_wd_cmd_valid <= 1'b0;
      o_wd_cmd <= `BWSUP_CMD_NONE;
      o_wd_cmd_data <= {DATA_W{1'b0}};
    end else begin
      o_wd_cmd_valid <= 1'b0;
      if (state == ST_CMD && cur_cmd != `BWSUP_CMD_NONE) begin
        o_wd_cmd_valid <= 1'b1;
        o_wd_cmd <= cur_cmd;
        last_cmd <= cur_cmd;
        // load guard takes minutes; others take the raw timeout
        if (cur_cmd == `BWSUP_CMD_ARM_LOAD)
          o_wd_cmd_data <= {{(DATA_W-8){1'b0}},
            lg_minutes(lg_opt)};
        else
          o_wd_cmd_data <= timeout[DATA_W-1:0];
      end
    end
  end

  // expiry capture and the self-test failure log strobe
  // the status word is kept whole so software can tell the roles apart;
  // only the role bits decide whether a failure must be logged
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      expiry <= `BWSUP_ZERO32;
      o_selftest_log <= 1'b0;
    end else begin
      o_selftest_log <= 1'b0;
      if (state == ST_WAIT && i_wd_done &&
        last_cmd == `BWSUP_CMD_READ_STATUS) begin
        expiry <= i_wd_rdata;
        // self-test guard failures are the host's to log
        o_selftest_log <=
          |i_wd_rdata[`BWSUP_EXP_HI:`BWSUP_EXP_LO];
      end
    end
  end

endmodule

// *** bwsup_consts.vh ***
// constants for the boot watchdog host-side sequencer
// assumes a 100 MHz system clock and word-aligned avalon-mm byte addresses
`ifndef BWSUP_CONSTS_VH
`define BWSUP_CONSTS_VH

// own register map (byte addresses)
`define BWSUP_A_CTRL 4'h0
`define BWSUP_A_STATUS 4'h4
`define BWSUP_A_TIMEOUT 4'h8
`define BWSUP_A_EXPIRY 4'hc

// ctrl register fields
`define BWSUP_C_GO 0
`define BWSUP_C_STEP_LO 1
`define BWSUP_C_STEP_HI 3
`define BWSUP_C_STEP_W 3

// host boot steps written into ctrl
`define BWSUP_S_RGUARD_LOAD 3'h0
`define BWSUP_S_POST_ENTER 3'h1
`define BWSUP_S_MEM_EXTEND 3'h2
`define BWSUP_S_POST_DONE 3'h3
`define BWSUP_S_BOOT_PWD 3'h4
`define BWSUP_S_OS_LOAD 3'h5
`define BWSUP_S_SETUP 3'h6
`define BWSUP_S_OS_UP 3'h7

// boot media codes in timeout[9:8], load-guard option in timeout[12:10]
`define BWSUP_M_HDD 2'h0
`define BWSUP_M_PXE 2'h1
`define BWSUP_M_REMOV 2'h2
`define BWSUP_M_UNKNOWN 2'h3
`define BWSUP_OPT_OFF 3'h0
`define BWSUP_OPT_MAX 3'h4

// field positions inside the timeout register
`define BWSUP_T_MEDIA_HI 9
`define BWSUP_T_MEDIA_LO 8
`define BWSUP_T_OPT_HI 12
`define BWSUP_T_OPT_LO 10

// expiry role bits returned by the device status read
`define BWSUP_EXP_HI 2
`define BWSUP_EXP_LO 0

// device-side watchdog command codes on o_wd_cmd; none ends a step
`define BWSUP_CMD_NONE 3'h0
`define BWSUP_CMD_LOAD_RGUARD 3'h1
`define BWSUP_CMD_ARM_STEST 3'h2
`define BWSUP_CMD_EXTEND 3'h3
`define BWSUP_CMD_DISABLE 3'h4
`define BWSUP_CMD_ARM_LOAD 3'h5
`define BWSUP_CMD_READ_STATUS 3'h6

// memory size threshold in MiB and load-guard minutes step
`define BWSUP_BIG_MEM_MB 16'h0400
`define BWSUP_LG_STEP_MIN 8'h05
`define BWSUP_ZERO32 32'h0000_0000

`endif

// *** bwsup_checker.sv ***
// checker for the host-side boot watchdog sequencer
// assumes it is bound to bwsup_host and sees only its ports
`timescale 1ns/1ps
`include "bwsup_consts.vh"
module bwsup_checker (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire o_wd_cmd_valid,
  input wire [2:0] o_wd_cmd,
  input wire [31:0] o_wd_cmd_data,
  input wire i_wd_done,
  input wire [31:0] i_wd_rdata,
  input wire o_selftest_log
);
  // accepted go write; the bench never sends go while busy
  wire go = i_avs_write && o_avs_waitrequest &&
    i_avs_address == `BWSUP_A_CTRL && i_avs_writedata[0];
  wire [2:0] stp = i_avs_writedata[3:1];
  wire dis = o_wd_cmd_valid && o_wd_cmd == `BWSUP_CMD_DISABLE;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  arm_stest_a: assert property (go && stp == `BWSUP_S_POST_ENTER |-> ##2
    (o_wd_cmd_valid && o_wd_cmd == `BWSUP_CMD_ARM_STEST)) else $error("no arm");
  stat_read_a: assert property (i_wd_done && o_wd_cmd == `BWSUP_CMD_ARM_STEST
    |-> ##3 (o_wd_cmd_valid && o_wd_cmd == `BWSUP_CMD_READ_STATUS))
    else $error("no status read");
  post_dis_a: assert property (go && stp == `BWSUP_S_POST_DONE |-> ##2 dis)
    else $error("post end not disabled");
  pwd_dis_a: assert property (go && stp == `BWSUP_S_BOOT_PWD |-> ##2 dis)
    else $error("password not disabled");
  setup_dis_a: assert property (go && stp == `BWSUP_S_SETUP |-> ##2 dis)
    else $error("setup not disabled");
  os_up_dis_a: assert property (go && stp == `BWSUP_S_OS_UP |-> ##2 dis)
    else $error("os up not disabled");
  load_arm_a: assert property (go && stp == `BWSUP_S_OS_LOAD |-> ##2 (dis ||
    o_wd_cmd_valid && o_wd_cmd == `BWSUP_CMD_ARM_LOAD)) else $error("bad load cmd");
  fail_log_a: assert property (i_wd_done && o_wd_cmd == `BWSUP_CMD_READ_STATUS &&
    i_wd_rdata[2:0] != 3'h0 |-> ##[1:2] o_selftest_log) else $error("no log");
endmodule
bind bwsup_host bwsup_checker u_chk (.i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_wd_cmd_valid(o_wd_cmd_valid),
  .o_wd_cmd(o_wd_cmd), .o_wd_cmd_data(o_wd_cmd_data), .i_wd_done(i_wd_done),
  .i_wd_rdata(i_wd_rdata), .o_selftest_log(o_selftest_log));

// *** bwsup_wd_model.sv ***
// device watchdog model facing the host sequencer
// assumes one-cycle command strobes; answers with a done pulse
`timescale 1ns/1ps
`include "bwsup_consts.vh"
module bwsup_wd_model (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_cmd_valid,
  input wire [2:0] i_cmd,
  input wire [31:0] i_cmd_data,
  input wire [3:0] i_delay,
  input wire [2:0] i_expired,
  output reg o_done,
  output reg [31:0] o_rdata
);
  reg [1:0] role;
  reg [31:0] count;
  reg [4:0] wait_n;
  reg [1:0] boot_cpu;
  // status toggles between answers so stale data is never trusted
  always @(posedge i_clk_sys) begin
    o_done <= 1'b0;
    o_rdata <= ~o_rdata;
    if (!i_resetn) begin
      role <= 2'h1;
      count <= 32'hffff_ffff;
      wait_n <= 5'h00;
      boot_cpu <= 2'h0;
      o_rdata <= 32'h0000_0000;
    end else begin
      if (role != 2'h0 && count != 32'h0000_0000) count <= count - 1;
      // reset guard running out moves on to the next bootstrap cpu
      if (role == 2'h1 && count == 32'h0000_0001) boot_cpu <= boot_cpu + 2'h1;
      if (i_cmd_valid) wait_n <= {1'b0, i_delay} + 5'h01;
      else if (wait_n != 5'h00) wait_n <= wait_n - 5'h01;
      if (wait_n == 5'h01) begin
        o_done <= 1'b1;
        case (i_cmd)
          `BWSUP_CMD_LOAD_RGUARD: role <= 2'h1;
          `BWSUP_CMD_ARM_STEST: role <= 2'h2;
          `BWSUP_CMD_DISABLE: role <= 2'h0;
          `BWSUP_CMD_ARM_LOAD: role <= 2'h3;
          `BWSUP_CMD_READ_STATUS: o_rdata <= {29'h0, i_expired};
          default: role <= role;
        endcase
        if (i_cmd != `BWSUP_CMD_DISABLE) count <= i_cmd_data;
      end
    end
  end
endmodule

// *** boot_watchdog_supervisor_tb.sv ***
// random boot-step bench for the host watchdog sequencer
// assumes the device model answers every command after a random delay
`timescale 1ns/1ps
`include "bwsup_consts.vh"
module boot_watchdog_supervisor_tb;
  reg clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0;
  reg [3:0] addr = 4'h0, dly = 4'h0;
  reg [2:0] expd = 3'h0, c0, clast;
  reg [31:0] wdat = 32'h0, d0, tmo, got;
  wire [31:0] rdat, cdat, wrd;
  wire wreq, cv, done, slog;
  wire [2:0] cmd;
  integer seed = 9477, err_count = 0, checks = 0, cyc = 0, ncmd, nlog, i;
  reg [14:0] mb;
  reg full;
  reg [4:0] e;
  always #5 clk = ~clk;
  bwsup_host dut (.i_clk_sys(clk), .i_resetn(resetn), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_wd_cmd_valid(cv),
    .o_wd_cmd(cmd), .o_wd_cmd_data(cdat), .i_wd_done(done),
    .i_wd_rdata(wrd), .o_selftest_log(slog));
  bwsup_wd_model u_dev (.i_clk_sys(clk), .i_resetn(resetn), .i_cmd_valid(cv),
    .i_cmd(cmd), .i_cmd_data(cdat), .i_delay(dly), .i_expired(expd),
    .o_done(done), .o_rdata(wrd));
  // record each command pulse and log pulse of one boot step
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin err_count = err_count + 1; end_sim; end
    if (cv === 1'b1) begin
      if (ncmd == 0) begin c0 <= cmd; d0 <= cdat; end
      clast <= cmd;
      ncmd <= ncmd + 1;
    end
    if (slog === 1'b1) nlog <= nlog + 1;
  end
  task av(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a; wdat <= d; wr <= w; rd <= !w;
      do @(posedge clk); while (wreq !== 1'b0);
      got = rdat;
      wr <= 1'b0; rd <= 1'b0;
    end
  endtask
  task chk(input string nm, input [31:0] ex, input [31:0] sn);
    begin
      checks = checks + 1;
      if (sn !== ex) begin
        $display("unexpected %s expected %h seen %h", nm, ex, sn);
        err_count = err_count + 1;
      end
    end
  endtask
  // expected command count and first command code for a step
  function [4:0] exp_f(input [2:0] s, input [31:0] t, input [14:0] m, input f);
    begin
      case (s)
        3'h0: exp_f = {2'h1, `BWSUP_CMD_LOAD_RGUARD};
        3'h1: exp_f = {2'h2, `BWSUP_CMD_ARM_STEST};
        3'h2: exp_f = (f && m > 15'h0400) ? {2'h1, `BWSUP_CMD_EXTEND} : 5'h00;
        3'h5: exp_f = (t[9] || t[12:10] == 3'h0 || t[12:10] > 3'h4) ?
          {2'h1, `BWSUP_CMD_DISABLE} : {2'h1, `BWSUP_CMD_ARM_LOAD};
        default: exp_f = {2'h1, `BWSUP_CMD_DISABLE};
      endcase
    end
  endfunction
  task end_sim;
    begin
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    av(1'b0, 4'h1, 32'h0);
    chk("unmapped", 32'h0, got);
    for (i = 0; i < 40; i = i + 1) begin
      tmo = $random(seed);
      mb = (i == 10) ? 15'h0400 : (i == 18) ? 15'h0401 : $random(seed);
      full = (i == 10 || i == 18) ? 1'b1 : $random(seed);
      dly <= $random(seed);
      expd <= $random(seed);
      av(1'b1, `BWSUP_A_TIMEOUT, tmo);
      av(1'b1, `BWSUP_A_STATUS, {16'h0, mb, full});
      av(1'b0, `BWSUP_A_STATUS, 32'h0);
      chk("status", {16'h0, mb, full}, got);
      av(1'b0, `BWSUP_A_TIMEOUT, 32'h0);
      chk("timeout", tmo, got);
      ncmd = 0; nlog = 0;
      av(1'b1, `BWSUP_A_CTRL, {28'h0, i[2:0], 1'b1});
      got = 32'h1;
      while (got[0] !== 1'b0) av(1'b0, `BWSUP_A_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      e = exp_f(i[2:0], tmo, mb, full);
      chk("count", e[4:3], ncmd);
      if (e[4:3] != 2'h0) chk("cmd", e[2:0], c0);
      if (e[2:0] == `BWSUP_CMD_ARM_LOAD) chk("minutes", tmo[12:10] * 5, d0);
      else if (e[2:0] < 3'h4 && e[4:3] != 2'h0) chk("data", tmo, d0);
      if (i[2:0] == 3'h1) chk("status", `BWSUP_CMD_READ_STATUS, clast);
      chk("log", (i[2:0] == 3'h1 && expd != 3'h0), nlog);
      if (i[2:0] == 3'h1) begin
        av(1'b0, `BWSUP_A_EXPIRY, 32'h0);
        chk("expiry", {29'h0, expd}, got);
      end
    end
    end_sim;
  end
endmodule
